/* logic/tsp_consts.svh */
// Constants shared by both ends of the two-wire touch sensor port.
// Assumes inclusion by bare name from the design files.
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH
`define TSP_ADDR_BITS 7
`define TSP_DATA_BITS 8
`define TSP_FRAME_BITS 9
`define TSP_DIR_READ 1'b1
`define TSP_DIR_WRITE 1'b0
`define TSP_CLK_HZ 200000000
`define TSP_SCL_HZ 400000
`define TSP_HALF_CYC ((`TSP_CLK_HZ / `TSP_SCL_HZ) / 2)
`define TSP_FRAME_MS 8
`define TSP_POWERUP_MS 230
`define TSP_CYC_PER_MS (`TSP_CLK_HZ / 1000)
`define TSP_POWERUP_CYC (`TSP_POWERUP_MS * `TSP_CYC_PER_MS)
`define TSP_FRAME_CYC (`TSP_FRAME_MS * `TSP_CYC_PER_MS)
`define TSP_DEV_ADDR 7'h1B
`endif

/* logic/tsp_pkg.sv */
// Types shared by both ends of the two-wire touch sensor port.
// Assumes the constants header is compiled alongside.
package tsp_pkg;
   typedef enum logic [4:0] {
      TSP_IDLE = 5'b00001,
      TSP_ADDR = 5'b00010,
      TSP_RX = 5'b00100,
      TSP_TX = 5'b01000,
      TSP_SKIP = 5'b10000
   } tsp_dev_state_t;
   typedef enum logic [5:0] {
      TSP_H_IDLE = 6'b000001,
      TSP_H_START = 6'b000010,
      TSP_H_BIT = 6'b000100,
      TSP_H_STOP = 6'b001000,
      TSP_H_DONE = 6'b010000,
      TSP_H_RSTART = 6'b100000
   } tsp_host_state_t;
endpackage : tsp_pkg

/* logic/tsp_bus_if.sv */
// Two-wire bus carrier joining the host end and the device end.
// Assumes pull-ups: a line is low when any party enables its driver.
`timescale 1ns/1ps
interface tsp_bus_if;
   logic scl_host_oe;
   logic sda_host_oe;
   logic scl_dev_oe;
   logic sda_dev_oe;
   logic scl;
   logic sda;
   // Wired AND of open-drain drivers with pull-ups.
   assign scl = ~(scl_host_oe | scl_dev_oe);
   assign sda = ~(sda_host_oe | sda_dev_oe);
   modport host (output scl_host_oe, output sda_host_oe, input scl, input sda);
   modport device (output scl_dev_oe, output sda_dev_oe, input scl, input sda);
endinterface : tsp_bus_if

/* logic/tsp_device.sv */
// Device end of the two-wire touch sensor port: target with clock stretching.
// Assumes the bus lines arrive asynchronously and the host drives all clocks.
`timescale 1ns/1ps
`include "tsp_consts.svh"
module tsp_device #(
   parameter int POWERUP_CYC = `TSP_POWERUP_CYC,
   parameter int FRAME_CYC = `TSP_FRAME_CYC,
   parameter logic [6:0] DEV_ADDR = `TSP_DEV_ADDR
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Bus
   tsp_bus_if.device bus,
   // Byte received from the host
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready,
   // Byte to send to the host
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   // Touch timing and bus status
   input wire logic [7:0] low_power_interval,
   input wire logic [7:0] detect_integrator_count,
   input wire logic touch_raw,
   output logic touch,
   output logic calibrated,
   output logic bus_busy
);
   initial begin
      if (POWERUP_CYC < 1 || FRAME_CYC < 1) begin
         $error("tsp_device: counts must be positive");
      end
   end

   logic scl_m, scl_s, sda_m, sda_s, scl_q, sda_q;
   always_ff @(posedge sys_clk) begin
      scl_m <= bus.scl;
      scl_s <= scl_m;
      sda_m <= bus.sda;
      sda_s <= sda_m;
      scl_q <= scl_s;
      sda_q <= sda_s;
   end
   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_det = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

   tsp_pkg::tsp_dev_state_t state;
   logic [3:0] bitcnt;
   logic [7:0] shreg;
   logic ack_phase, sda_oe, scl_oe, read_mode, host_nack;

   // Two-entry buffer on the received path so a stalled user loses no byte.
   logic [7:0] rbuf [2];
   logic [1:0] rcnt;
   logic rwr, rptr;
   logic rd_fire;
   assign rd_fire = rx_valid & rx_ready;
   assign rx_valid = rcnt != 2'd0;
   assign rx_data = rbuf[rptr];

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bus_busy <= 1'b0;
      end else if (start_det) begin
         bus_busy <= 1'b1;
      end else if (stop_det) begin
         bus_busy <= 1'b0;
      end
   end

   logic push;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= tsp_pkg::TSP_IDLE;
         bitcnt <= 4'd0;
         shreg <= 8'h00;
         ack_phase <= 1'b0;
         sda_oe <= 1'b0;
         read_mode <= 1'b0;
         host_nack <= 1'b0;
         push <= 1'b0;
      end else begin
         push <= 1'b0;
         if (start_det) begin
            state <= tsp_pkg::TSP_ADDR;
            bitcnt <= 4'd0;
            ack_phase <= 1'b0;
            sda_oe <= 1'b0;
            host_nack <= 1'b0;
         end else if (stop_det) begin
            state <= tsp_pkg::TSP_IDLE;
            sda_oe <= 1'b0;
         end else begin
            unique case (state)
               tsp_pkg::TSP_IDLE, tsp_pkg::TSP_SKIP: begin
                  sda_oe <= 1'b0;
               end
               tsp_pkg::TSP_ADDR, tsp_pkg::TSP_RX: begin
                  if (scl_rise && !ack_phase) begin
                     shreg <= {shreg[6:0], sda_s};
                     bitcnt <= bitcnt + 4'd1;
                  end
                  if (scl_fall && !ack_phase && bitcnt == 4'd8) begin
                     ack_phase <= 1'b1;
                     if (state == tsp_pkg::TSP_ADDR) begin
                        if (shreg[7:1] == DEV_ADDR) begin
                           sda_oe <= 1'b1;
                           read_mode <= shreg[0] == `TSP_DIR_READ;
                        end else begin
                           state <= tsp_pkg::TSP_SKIP;
                        end
                     end else begin
                        sda_oe <= 1'b1;
                        push <= 1'b1;
                     end
                  end else if (scl_fall && ack_phase) begin
                     ack_phase <= 1'b0;
                     bitcnt <= 4'd0;
                     sda_oe <= 1'b0;
                     if (state == tsp_pkg::TSP_ADDR && read_mode) begin
                        state <= tsp_pkg::TSP_TX;
                        shreg <= tx_data;
                        sda_oe <= tx_valid & ~tx_data[7];
                        bitcnt <= 4'd1;
                     end else begin
                        state <= tsp_pkg::TSP_RX;
                     end
                  end
               end
               tsp_pkg::TSP_TX: begin
                  if (host_nack) begin
                     sda_oe <= 1'b0;
                  end else if (scl_oe) begin
                     // The clock is held low while waiting, so no edge can arrive here.
                     if (tx_valid) begin
                        shreg <= tx_data;
                        sda_oe <= ~tx_data[7];
                     end
                  end else if (scl_fall && !ack_phase) begin
                     if (bitcnt == 4'd8) begin
                        ack_phase <= 1'b1;
                        sda_oe <= 1'b0;
                     end else begin
                        sda_oe <= ~shreg[7 - bitcnt[2:0]];
                        bitcnt <= bitcnt + 4'd1;
                     end
                  end else if (scl_rise && ack_phase) begin
                     host_nack <= sda_s;
                  end else if (scl_fall && ack_phase) begin
                     ack_phase <= 1'b0;
                     shreg <= tx_data;
                     sda_oe <= tx_valid & ~tx_data[7];
                     bitcnt <= 4'd1;
                  end
               end
               default: state <= tsp_pkg::TSP_IDLE;
            endcase
         end
      end
   end

   // Stretch while a byte cannot be stored or none is ready to send.
   logic need_tx;
   assign need_tx = (state == tsp_pkg::TSP_TX && ack_phase && !host_nack)
      || (state == tsp_pkg::TSP_ADDR && ack_phase && read_mode);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         scl_oe <= 1'b0;
      end else if (start_det || stop_det) begin
         scl_oe <= 1'b0;
      end else if (scl_fall && ack_phase) begin
         scl_oe <= (need_tx && !tx_valid) || (rcnt == 2'd2 && state == tsp_pkg::TSP_RX);
      end else if (scl_oe && (state == tsp_pkg::TSP_TX ? tx_valid : rcnt != 2'd2)) begin
         scl_oe <= 1'b0;
      end
   end
   assign tx_ready = scl_fall && ack_phase && need_tx && tx_valid
      || scl_oe && state == tsp_pkg::TSP_TX && tx_valid;
   assign bus.sda_dev_oe = sda_oe;
   assign bus.scl_dev_oe = scl_oe;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rcnt <= 2'd0;
         rptr <= 1'b0;
         rwr <= 1'b0;
         rbuf[0] <= 8'h00;
         rbuf[1] <= 8'h00;
      end else begin
         if (push && rcnt != 2'd2) begin
            rbuf[rwr] <= shreg;
            rwr <= ~rwr;
         end
         if (rd_fire) begin
            rptr <= ~rptr;
         end
         rcnt <= rcnt + {1'b0, push && rcnt != 2'd2} - {1'b0, rd_fire};
      end
   end

   // Touch path: calibration wait, then bounded detection latency.
   logic [31:0] pu_cnt, tr_cnt;
   logic [7:0] lp_eff, di_eff;
   logic [9:0] frames_limit;
   assign lp_eff = (low_power_interval == 8'h00) ? 8'h01 : low_power_interval;
   assign di_eff = (detect_integrator_count < 8'h02) ? 8'h02 : detect_integrator_count;
   assign frames_limit = {2'b00, lp_eff} + {2'b00, di_eff};
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pu_cnt <= 32'h0000_0000;
         calibrated <= 1'b0;
      end else if (pu_cnt == 32'(POWERUP_CYC - 1)) begin
         calibrated <= 1'b1;
      end else begin
         pu_cnt <= pu_cnt + 32'h0000_0001;
      end
   end
   logic [9:0] frames;
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !touch_raw || !calibrated) begin
         tr_cnt <= 32'h0000_0000;
         frames <= 10'd0;
         touch <= 1'b0;
      end else if (!touch) begin
         if (tr_cnt == 32'(FRAME_CYC - 1)) begin
            tr_cnt <= 32'h0000_0000;
            frames <= frames + 10'd1;
            touch <= (frames + 10'd1) >= frames_limit;
         end else begin
            tr_cnt <= tr_cnt + 32'h0000_0001;
         end
      end
   end
endmodule : tsp_device

/* logic/tsp_host.sv */
// Host end of the two-wire touch sensor port: bus controller.
// Assumes the bus lines arrive asynchronously; the host makes the clock.
`timescale 1ns/1ps
`include "tsp_consts.svh"
module tsp_host #(
   parameter int HALF_CYC = `TSP_HALF_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Bus
   tsp_bus_if.host bus,
   // Command: address, direction, byte count
   input wire logic cmd_valid,
   input wire logic [6:0] cmd_addr,
   input wire logic cmd_read,
   input wire logic [7:0] cmd_len,
   output logic cmd_ready,
   // Write bytes
   input wire logic wr_valid,
   input wire logic [7:0] wr_data,
   output logic wr_ready,
   // Read bytes
   output logic rd_valid,
   output logic [7:0] rd_data,
   // Status
   output logic nack_seen,
   output logic done
);
   initial begin
      if (HALF_CYC < 2) begin
         $error("tsp_host: HALF_CYC too small");
      end
   end
   logic scl_m, scl_s, sda_m, sda_s;
   always_ff @(posedge sys_clk) begin
      scl_m <= bus.scl;
      scl_s <= scl_m;
      sda_m <= bus.sda;
      sda_s <= sda_m;
   end
   tsp_pkg::tsp_host_state_t state;
   logic [15:0] tcnt;
   logic phase;
   logic [3:0] bitn;
   logic [8:0] sh;
   logic [7:0] left;
   logic is_addr, rd;
   logic scl_oe, sda_oe;
   logic tick;
   assign tick = tcnt == 16'(HALF_CYC - 1);
   assign cmd_ready = state == tsp_pkg::TSP_H_IDLE;
   // A write byte is loaded at every acknowledged slot that another byte follows.
   logic load_pt, wr_hold;
   assign load_pt = state == tsp_pkg::TSP_H_BIT && tick && phase && bitn == 4'd8
      && !rd && !sda_s && (is_addr || left > 8'd1);
   // Without a byte to send the clock stays high in the slot, which costs bus time only.
   assign wr_hold = load_pt && !wr_valid;
   assign wr_ready = load_pt && wr_valid;
   assign bus.scl_host_oe = scl_oe;
   assign bus.sda_host_oe = sda_oe;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= tsp_pkg::TSP_H_IDLE;
         tcnt <= 16'h0000;
         phase <= 1'b0;
         bitn <= 4'd0;
         sh <= 9'h000;
         left <= 8'h00;
         is_addr <= 1'b0;
         rd <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
         nack_seen <= 1'b0;
         done <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         done <= 1'b0;
         // Hold time while the device stretches: the counter waits for a real high.
         if (state != tsp_pkg::TSP_H_IDLE && !(phase && !scl_s && !scl_oe) && !wr_hold) begin
            tcnt <= tick ? 16'h0000 : tcnt + 16'h0001;
         end
         unique case (state)
            tsp_pkg::TSP_H_IDLE: begin
               if (cmd_valid) begin
                  state <= tsp_pkg::TSP_H_START;
                  sh <= {cmd_addr, cmd_read, 1'b1};
                  rd <= cmd_read;
                  left <= cmd_len;
                  is_addr <= 1'b1;
                  nack_seen <= 1'b0;
                  tcnt <= 16'h0000;
               end
            end
            tsp_pkg::TSP_H_START, tsp_pkg::TSP_H_RSTART: begin
               if (tick) begin
                  sda_oe <= 1'b1;
                  scl_oe <= sda_oe;
                  if (sda_oe) begin
                     state <= tsp_pkg::TSP_H_BIT;
                     phase <= 1'b0;
                     bitn <= 4'd0;
                  end
               end
            end
            tsp_pkg::TSP_H_BIT: begin
               if (tick && !phase) begin
                  sda_oe <= ~sh[8];
                  scl_oe <= 1'b0;
                  phase <= 1'b1;
               end else if (tick && phase && !wr_hold) begin
                  scl_oe <= 1'b1;
                  phase <= 1'b0;
                  sh <= {sh[7:0], sda_s};
                  bitn <= bitn + 4'd1;
                  if (bitn == 4'd8) begin
                     bitn <= 4'd0;
                     is_addr <= 1'b0;
                     if ((is_addr || !rd) && sda_s) begin
                        nack_seen <= 1'b1;
                        state <= tsp_pkg::TSP_H_STOP;
                     end else if (!is_addr && rd) begin
                        rd_valid <= 1'b1;
                        rd_data <= sh[7:0];
                     end
                     if (!is_addr) begin
                        left <= left - 8'd1;
                     end
                     if (!is_addr && left == 8'd1) begin
                        state <= tsp_pkg::TSP_H_STOP;
                     end
                     if (rd) begin
                        sh <= {8'hFF, (left <= 8'd2 && !is_addr) || (is_addr && left == 8'd1)};
                     end else begin
                        sh <= {wr_data, 1'b1};
                     end
                  end
               end
            end
            tsp_pkg::TSP_H_STOP: begin
               if (tick && !phase) begin
                  sda_oe <= 1'b1;
                  phase <= 1'b1;
               end else if (tick && phase) begin
                  scl_oe <= 1'b0;
                  state <= tsp_pkg::TSP_H_DONE;
               end
            end
            tsp_pkg::TSP_H_DONE: begin
               if (tick && scl_s) begin
                  sda_oe <= 1'b0;
                  done <= 1'b1;
                  phase <= 1'b0;
                  state <= tsp_pkg::TSP_H_IDLE;
               end
            end
            default: state <= tsp_pkg::TSP_H_IDLE;
         endcase
      end
   end
endmodule : tsp_host

/* sim/tsp_properties.sv */
// Checker watching the two-wire bus wires between the host and device ends.
// Assumes it sits beside the bus instance, with the device address handed on.
`timescale 1ns/1ps
module tsp_properties #(
   parameter logic [6:0] DEV_ADDR = 7'h00
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Bus wires
   input wire logic scl_host_oe,
   input wire logic sda_host_oe,
   input wire logic scl_dev_oe,
   input wire logic sda_dev_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   logic scl_q, sda_q, busy, addr_fr, foreign, start_c, stop_c, rise;
   logic [3:0] bits;
   logic [7:0] sh;
   assign start_c = scl && scl_q && sda_q && !sda;
   assign stop_c = scl && scl_q && !sda_q && sda;
   assign rise = scl && !scl_q;
   always_ff @(posedge sys_clk) begin
      scl_q <= scl;
      sda_q <= sda;
   end
   always_ff @(posedge sys_clk) begin
      busy <= !sys_rst && !stop_c && (busy || start_c);
   end
   // Bit position and address byte restart at every START.
   always_ff @(posedge sys_clk) begin
      if (sys_rst || start_c) begin
         bits <= 4'h0;
         addr_fr <= !sys_rst;
         sh <= 8'h00;
      end else if (rise) begin
         bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
         addr_fr <= addr_fr && bits != 4'h8;
         sh <= (addr_fr && bits != 4'h8) ? {sh[6:0], sda} : sh;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (sys_rst || start_c) begin
         foreign <= 1'b0;
      end else if (rise && bits == 4'h8 && addr_fr && sh[7:1] != DEV_ADDR) begin
         foreign <= 1'b1;
      end
   end
   sequence s_ninth;
      rise && bits == 4'h8;
   endsequence
   a_addr_ack_own: assert property (
      s_ninth ##0 (addr_fr && sh[7:1] == DEV_ADDR) |-> sda_dev_oe && !sda_host_oe)
      else $error("Own address not acknowledged.");
   a_foreign_nack: assert property (
      s_ninth ##0 (addr_fr && sh[7:1] != DEV_ADDR) |-> !sda_dev_oe)
      else $error("Foreign address acknowledged.");
   a_foreign_quiet: assert property (foreign |-> !sda_dev_oe && !scl_dev_oe)
      else $error("Device drove bus after foreign address.");
   a_write_ack: assert property (
      s_ninth ##0 (!addr_fr && !sh[0] && !foreign) |-> sda_dev_oe && !sda_host_oe)
      else $error("Written byte not acknowledged.");
   a_read_release: assert property (
      s_ninth ##0 (!addr_fr && sh[0]) |-> !sda_dev_oe)
      else $error("Device held data in host acknowledge slot.");
   a_dev_sda_hold: assert property (scl && scl_q |-> $stable(sda_dev_oe))
      else $error("Device changed data while clock high.");
   a_idle_quiet: assert property (!busy |-> !sda_dev_oe && !scl_dev_oe)
      else $error("Device drove a free bus.");
   a_stretch_low: assert property (
      $rose(scl_dev_oe) |-> !scl_q && bits == 4'h0)
      else $error("Clock stretch outside a frame gap.");
   a_start_clocks: assert property (start_c |-> ##[1:200] !scl)
      else $error("No clock pulse after START.");
endmodule : tsp_properties

/* sim/touch_sensor_i2c_slave_port_tb.sv */
// Bench joining the host end and the device end over one two-wire bus.
// Assumes short power-up and frame counts on the device for a quick run.
`timescale 1ns/1ps
`include "tsp_consts.svh"
module touch_sensor_i2c_slave_port_tb;
   localparam int PWR = 100;
   localparam int FRM = 20;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic rx_valid, rx_ready, tx_valid, tx_ready, cmd_valid, cmd_read, cmd_ready, wr_valid;
   logic wr_ready, rd_valid, nack_seen, done, touch_raw, touch, calibrated, bus_busy;
   logic [7:0] rx_data, tx_data, wr_data, rd_data, cmd_len;
   logic [7:0] low_power_interval, detect_integrator_count;
   logic [6:0] cmd_addr;
   logic [7:0] wr_buf [4];
   logic [7:0] tx_buf [4];
   logic [7:0] got_q [$];
   int wr_idx = 0;
   int tx_idx = 0;
   int bad_count = 0;
   int samples_checked = 0;
   tsp_bus_if bus ();
   tsp_device #(.POWERUP_CYC(PWR), .FRAME_CYC(FRM), .DEV_ADDR(`TSP_DEV_ADDR)) i_tsp_device (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .low_power_interval(low_power_interval),
      .detect_integrator_count(detect_integrator_count), .touch_raw(touch_raw),
      .touch(touch), .calibrated(calibrated), .bus_busy(bus_busy));
   tsp_host #(.HALF_CYC(40)) i_tsp_host (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .cmd_valid(cmd_valid),
      .cmd_addr(cmd_addr), .cmd_read(cmd_read), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
      .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
      .rd_data(rd_data), .nack_seen(nack_seen), .done(done));
   tsp_properties #(.DEV_ADDR(`TSP_DEV_ADDR)) i_tsp_properties (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_host_oe(bus.scl_host_oe),
      .sda_host_oe(bus.sda_host_oe), .scl_dev_oe(bus.scl_dev_oe),
      .sda_dev_oe(bus.sda_dev_oe), .scl(bus.scl), .sda(bus.sda));
   always #2.5 sys_clk = ~sys_clk;
   // Both byte streams land in one queue; only one direction runs at a time.
   always @(posedge sys_clk) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) got_q.push_back(rx_data);
      if (rd_valid === 1'b1) got_q.push_back(rd_data);
      if (wr_ready === 1'b1) wr_idx <= wr_idx + 1;
      if (tx_ready === 1'b1) tx_idx <= tx_idx + 1;
   end
   always @(negedge sys_clk) begin
      wr_data <= wr_buf[wr_idx];
      tx_data <= tx_buf[tx_idx];
   end
   task automatic summarize();
      $display("Checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_byte
   task automatic chk_bit(input string name, input logic exp, input logic got);
      chk_byte(name, {7'h00, exp}, {7'h00, got});
   endtask : chk_bit
   // Index picks done, device stretch, calibrated or touch.
   task automatic wait_hi(input string name, input int which, input int lim);
      logic [3:0] v;
      for (int k = 0; k <= lim; k++) begin
         @(posedge sys_clk);
         v = {touch, calibrated, bus.scl_dev_oe, done};
         if (v[which] === 1'b1) return;
      end
      bad_count++;
      $display("ERROR %s expected 1 seen timeout", name);
      summarize();
   endtask : wait_hi
   task automatic run_cmd(input logic [6:0] a, input logic r, input logic [7:0] n);
      @(negedge sys_clk);
      chk_bit("cmd_ready", 1'b1, cmd_ready);
      got_q.delete();
      {cmd_addr, cmd_read, cmd_len, cmd_valid} = {a, r, n, 1'b1};
      @(negedge sys_clk);
      cmd_valid = 1'b0;
   endtask : run_cmd
   task automatic t_write();
      wr_buf = '{8'hA5, 8'h3C, 8'h81, 8'h00};
      {wr_idx, rx_ready, wr_valid} = {32'h0000_0000, 1'b0, 1'b1};
      run_cmd(`TSP_DEV_ADDR, `TSP_DIR_WRITE, 8'h03);
      wait_hi("stretch", 1, 10000);
      repeat (100) @(negedge sys_clk);
      chk_bit("scl", 1'b0, bus.scl);
      chk_bit("bus_busy", 1'b1, bus_busy);
      rx_ready = 1'b1;
      wait_hi("done", 0, 10000);
      @(negedge sys_clk);
      chk_bit("nack_seen", 1'b0, nack_seen);
      chk_byte("rx count", 8'h03, 8'(got_q.size()));
      for (int i = 0; i < 3; i++) chk_byte("rx byte", wr_buf[i], got_q[i]);
      repeat (4) @(negedge sys_clk);
      chk_bit("bus_busy", 1'b0, bus_busy);
      $display("Test write with stall done");
   endtask : t_write
   task automatic t_read();
      tx_buf = '{8'hC3, 8'h5A, 8'h96, 8'h0F};
      {tx_idx, tx_valid, wr_valid} = {32'h0000_0000, 1'b1, 1'b0};
      run_cmd(`TSP_DEV_ADDR, `TSP_DIR_READ, 8'h02);
      wait_hi("done", 0, 10000);
      @(negedge sys_clk);
      tx_valid = 1'b0;
      chk_byte("rd count", 8'h02, 8'(got_q.size()));
      for (int i = 0; i < 2; i++) chk_byte("rd byte", tx_buf[i], got_q[i]);
      chk_byte("tx taken", 8'h02, 8'(tx_idx));
      $display("Test read done");
   endtask : t_read
   task automatic t_read_stall();
      tx_buf = '{8'h69, 8'h00, 8'h00, 8'h00};
      {tx_idx, tx_valid} = {32'h0000_0000, 1'b0};
      run_cmd(`TSP_DEV_ADDR, `TSP_DIR_READ, 8'h01);
      wait_hi("tx stretch", 1, 10000);
      repeat (50) @(negedge sys_clk);
      chk_bit("scl", 1'b0, bus.scl);
      tx_valid = 1'b1;
      wait_hi("done", 0, 10000);
      @(negedge sys_clk);
      tx_valid = 1'b0;
      chk_byte("rd count", 8'h01, 8'(got_q.size()));
      chk_byte("rd byte", 8'h69, got_q[0]);
      chk_byte("tx taken", 8'h01, 8'(tx_idx));
      $display("Test read with stall done");
   endtask : t_read_stall
   task automatic t_foreign();
      {wr_idx, wr_valid} = {32'h0000_0000, 1'b1};
      run_cmd(`TSP_DEV_ADDR ^ 7'h01, `TSP_DIR_WRITE, 8'h01);
      wait_hi("done", 0, 10000);
      @(negedge sys_clk);
      chk_bit("nack_seen", 1'b1, nack_seen);
      chk_byte("rx count", 8'h00, 8'(got_q.size()));
      $display("Test foreign address done");
   endtask : t_foreign
   task automatic t_touch();
      @(negedge sys_clk);
      chk_bit("touch idle", 1'b0, touch);
      touch_raw = 1'b1;
      wait_hi("touch", 3, (2 + 3) * FRM + 8);
      @(negedge sys_clk);
      touch_raw = 1'b0;
      $display("Test touch response done");
   endtask : t_touch
   initial begin
      {rx_ready, tx_valid, cmd_valid, cmd_read, wr_valid, touch_raw} = 6'h00;
      {cmd_addr, cmd_len} = '0;
      {low_power_interval, detect_integrator_count} = {8'h02, 8'h03};
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      chk_bit("calibrated", 1'b0, calibrated);
      wait_hi("calibrated", 2, PWR + 8);
      $display("Test power-up done");
      t_write();
      t_read();
      t_read_stall();
      t_foreign();
      t_touch();
      summarize();
   end
endmodule : touch_sensor_i2c_slave_port_tb
